// >>> design/lcd_column_driver_map.vh
// Constants for the LCD column driver chain
`ifndef LCD_COLUMN_DRIVER_MAP_VH
`define LCD_COLUMN_DRIVER_MAP_VH
`define COLUMN_COUNT      80
`define NIBBLE_WIDTH      4
`define NIBBLES_PER_ROW   5'h14
`define FILL_POS_WIDTH    5
`define FILL_POS_RESET    5'h00
`define LEVEL_OUTER_HIGH  2'h0
`define LEVEL_OUTER_LOW   2'h1
`define LEVEL_INNER_HIGH  2'h2
`define LEVEL_INNER_LOW   2'h3
`endif

// >>> design/lcd_column_driver_chain.v
// Digital core of an 80-column LCD segment driver with enable chain
// Functional notes
// RULE_01: Direction input sets enable shift direction.
// RULE_02: Disabled driver holds internal clock, data low.
// RULE_03: Board chains enables; first input tied high.
// RULE_04: Driver passes enable after 80 bits itself.
// RULE_05: Bit position set by order within window.
// RULE_06: Latch pulse fall copies row to latch.
// RULE_07: Bit and polarity pick one of four levels.
// RULE_08: Eighty columns change only at latch fall; code also changes them whenever the synchronised polarity changes.
// RULE_09: Four data bits per shift clock cycle.
// RULE_10: Capture nibble on shift clock falling edge.
// RULE_11: Direction high: port A out, B in.
// RULE_12: Latch clears enable out; 80 bits raise it.
// RULE_13: Direction maps first nibble to column end.
// RULE_14: Count twenty captures; latch resets counter.
// RULE_15: Controller fills chain before latch, steps polarity.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_column_driver_map.vh"
module lcd_column_driver_chain (
  // Clock and reset
  input  wire         CLK,
  input  wire         RST_N,
  // Controller pins
  input  wire         SHIFT_DIRECTION_SELECT,
  input  wire         NIBBLE_SHIFT_CLOCK,
  input  wire         LINE_LATCH_PULSE,
  input  wire         FRAME_POLARITY,
  input  wire [3:0]   DISPLAY_NIBBLE_IN,
  // Enable chain ports, three signals each
  input  wire         CHAIN_ENABLE_PORT_A_I,
  output reg          CHAIN_ENABLE_PORT_A_O,
  output reg          CHAIN_ENABLE_PORT_A_OE,
  input  wire         CHAIN_ENABLE_PORT_B_I,
  output reg          CHAIN_ENABLE_PORT_B_O,
  output reg          CHAIN_ENABLE_PORT_B_OE,
  // Column level selects, two bits per column
  output reg  [159:0] COLUMN_OUTPUTS
);

  // ==========================================================
  // Input synchronisers, two flip-flops per pin
  reg        dir_meta_reg;
  reg        dir_reg;
  reg        sclk_meta_reg;
  reg        sclk_reg;
  reg        latch_meta_reg;
  reg        latch_reg;
  reg        pol_meta_reg;
  reg        pol_reg;
  reg        en_a_meta_reg;
  reg        en_a_reg;
  reg        en_b_meta_reg;
  reg        en_b_reg;
  reg  [3:0] nib_meta_reg;
  reg  [3:0] nib_reg;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dir_meta_reg   <= 1'h0;
      dir_reg        <= 1'h0;
      sclk_meta_reg  <= 1'h0;
      sclk_reg       <= 1'h0;
      latch_meta_reg <= 1'h0;
      latch_reg      <= 1'h0;
      pol_meta_reg   <= 1'h0;
      pol_reg        <= 1'h0;
      en_a_meta_reg  <= 1'h0;
      en_a_reg       <= 1'h0;
      en_b_meta_reg  <= 1'h0;
      en_b_reg       <= 1'h0;
      nib_meta_reg   <= 4'h0;
      nib_reg        <= 4'h0;
    end else begin
      dir_meta_reg   <= SHIFT_DIRECTION_SELECT;
      dir_reg        <= dir_meta_reg;
      sclk_meta_reg  <= NIBBLE_SHIFT_CLOCK;
      sclk_reg       <= sclk_meta_reg;
      latch_meta_reg <= LINE_LATCH_PULSE;
      latch_reg      <= latch_meta_reg;
      pol_meta_reg   <= FRAME_POLARITY;
      pol_reg        <= pol_meta_reg;
      en_a_meta_reg  <= CHAIN_ENABLE_PORT_A_I;
      en_a_reg       <= en_a_meta_reg;
      en_b_meta_reg  <= CHAIN_ENABLE_PORT_B_I;
      en_b_reg       <= en_b_meta_reg;
      nib_meta_reg   <= DISPLAY_NIBBLE_IN; // RULE_09
      nib_reg        <= nib_meta_reg;
    end
  end

  // ==========================================================
  // Enable selection and power-save gating
  wire       enable_in;
  wire       active;
  wire       sclk_gated;
  wire [3:0] nib_gated;
  reg        full_reg;

  assign enable_in  = dir_reg ? en_b_reg : en_a_reg; // RULE_11
  assign active     = enable_in & ~full_reg;
  assign sclk_gated = sclk_reg & active; // RULE_02
  assign nib_gated  = nib_reg & {4{active}}; // RULE_02

  // ==========================================================
  // Edge detection
  reg        sclk_d_reg;
  reg        latch_d_reg;
  wire       sclk_fall;
  wire       latch_fall;

  // A window that closes while the clock is high is no fall
  assign sclk_fall  = sclk_d_reg & ~sclk_gated & active; // RULE_10
  assign latch_fall = latch_d_reg & ~latch_reg; // RULE_06

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sclk_d_reg  <= 1'h0;
      latch_d_reg <= 1'h0;
    end else begin
      sclk_d_reg  <= sclk_gated;
      latch_d_reg <= latch_reg;
    end
  end

  // ==========================================================
  // Fill counter
  reg  [4:0] fill_pos_reg;
  reg  [4:0] fill_pos_next;
  reg        full_next;

  always @* begin
    fill_pos_next = fill_pos_reg;
    full_next     = full_reg;
    if (latch_fall) begin
      fill_pos_next = `FILL_POS_RESET; // RULE_14
      full_next     = 1'h0; // RULE_12
    end else if (sclk_fall) begin
      fill_pos_next = fill_pos_reg + 5'h01; // RULE_14
      if (fill_pos_reg == `NIBBLES_PER_ROW - 5'h01)
        full_next = 1'h1; // RULE_04
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fill_pos_reg <= `FILL_POS_RESET;
      full_reg     <= 1'h0;
    end else begin
      fill_pos_reg <= fill_pos_next;
      full_reg     <= full_next;
    end
  end

  // ==========================================================
  // Data register, one nibble per capture
  reg  [79:0] row_reg;
  reg  [6:0]  base_up;
  reg  [6:0]  base_down;
  integer     k;

  always @* begin
    base_up   = {fill_pos_reg, 2'h0}; // RULE_05
    base_down = 7'h4F - {fill_pos_reg, 2'h0}; // RULE_13
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      row_reg <= 80'h0;
    end else if (sclk_fall && !latch_fall) begin
      for (k = 0; k < `NIBBLE_WIDTH; k = k + 1) begin
        if (dir_reg)
          row_reg[base_down - 7'h3 + k] <= nib_gated[k]; // RULE_01
        else
          row_reg[base_up + 7'h3 - k] <= nib_gated[k]; // RULE_01
      end
    end
  end

  // ==========================================================
  // Output latch
  reg  [79:0] latched_reg;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      latched_reg <= 80'h0;
    end else if (latch_fall) begin
      latched_reg <= row_reg; // RULE_06
    end
  end

  // ==========================================================
  // Enable port drive
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CHAIN_ENABLE_PORT_A_O  <= 1'h0;
      CHAIN_ENABLE_PORT_A_OE <= 1'h0;
      CHAIN_ENABLE_PORT_B_O  <= 1'h0;
      CHAIN_ENABLE_PORT_B_OE <= 1'h0;
    end else begin
      CHAIN_ENABLE_PORT_A_OE <= dir_reg; // RULE_11
      CHAIN_ENABLE_PORT_B_OE <= ~dir_reg; // RULE_11
      CHAIN_ENABLE_PORT_A_O  <= dir_reg & full_reg; // RULE_12
      CHAIN_ENABLE_PORT_B_O  <= ~dir_reg & full_reg; // RULE_12
    end
  end

  // ==========================================================
  // Column level select
  integer c;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      COLUMN_OUTPUTS <= 160'h0;
    end else begin
      for (c = 0; c < `COLUMN_COUNT; c = c + 1) begin
        case ({latched_reg[c], pol_reg}) // RULE_07 RULE_08
          2'h3:    COLUMN_OUTPUTS[2*c +: 2] <= `LEVEL_OUTER_HIGH;
          2'h2:    COLUMN_OUTPUTS[2*c +: 2] <= `LEVEL_OUTER_LOW;
          2'h1:    COLUMN_OUTPUTS[2*c +: 2] <= `LEVEL_INNER_HIGH;
          default: COLUMN_OUTPUTS[2*c +: 2] <= `LEVEL_INNER_LOW;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// >>> sim/lcd_chain_chk.sv
// Port checker for the LCD column driver chain
`timescale 1ns/1ps
`default_nettype none
module lcd_chain_chk (
  // Clock, reset and controller pins
  input wire logic         CLK, RST_N, SHIFT_DIRECTION_SELECT,
  input wire logic         NIBBLE_SHIFT_CLOCK, LINE_LATCH_PULSE,
  input wire logic         FRAME_POLARITY,
  input wire logic [3:0]   DISPLAY_NIBBLE_IN,
  // Enable chain and columns
  input wire logic         CHAIN_ENABLE_PORT_A_I, CHAIN_ENABLE_PORT_A_O,
  input wire logic         CHAIN_ENABLE_PORT_A_OE, CHAIN_ENABLE_PORT_B_I,
  input wire logic         CHAIN_ENABLE_PORT_B_O, CHAIN_ENABLE_PORT_B_OE,
  input wire logic [159:0] COLUMN_OUTPUTS
);
  wire s = SHIFT_DIRECTION_SELECT, f = FRAME_POLARITY;
  wire ao = CHAIN_ENABLE_PORT_A_OE, bo = CHAIN_ENABLE_PORT_B_OE;
  wire eo = CHAIN_ENABLE_PORT_A_O | CHAIN_ENABLE_PORT_B_O;
  wire ei = CHAIN_ENABLE_PORT_A_I | CHAIN_ENABLE_PORT_B_I;
  wire [159:0] c = COLUMN_OUTPUTS;
  logic [3:0] q_reg;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Cycles since the last latch pulse or polarity step
  always @(posedge CLK or negedge RST_N)
    if (!RST_N) q_reg <= 4'h0;
    else q_reg <= (LINE_LATCH_PULSE || $changed(f)) ?
                  4'h0 : q_reg + {3'h0, ~&q_reg};
  a_out_a: assert property (s [*6] |-> ao && !bo)
    else $error("port A not output");
  b_out_a: assert property ((!s) [*6] |-> bo && !ao)
    else $error("port B not output");
  en_clear_a: assert property ($fell(LINE_LATCH_PULSE) |-> ##8 !eo)
    else $error("enable out not cleared");
  en_gate_a: assert property ($rose(eo) |-> $past(ei, 3))
    else $error("enable out without enable in");
  en_fall_a: assert property ($rose(eo) |-> !$past(NIBBLE_SHIFT_CLOCK, 4))
    else $error("enable out not after shift fall");
  col_hold_a: assert property (!$stable(c) |-> q_reg < 4'h8)
    else $error("columns changed without latch");
  pol_hi_a: assert property (f [*8] |-> !c[0] && !c[158])
    else $error("level wrong for high polarity");
  pol_lo_a: assert property ((!f) [*8] |-> c[0] && c[158])
    else $error("level wrong for low polarity");
endmodule
bind lcd_column_driver_chain lcd_chain_chk chk (.CLK, .RST_N,
  .SHIFT_DIRECTION_SELECT, .NIBBLE_SHIFT_CLOCK, .LINE_LATCH_PULSE,
  .FRAME_POLARITY, .DISPLAY_NIBBLE_IN, .CHAIN_ENABLE_PORT_A_I,
  .CHAIN_ENABLE_PORT_A_O, .CHAIN_ENABLE_PORT_A_OE, .CHAIN_ENABLE_PORT_B_I,
  .CHAIN_ENABLE_PORT_B_O, .CHAIN_ENABLE_PORT_B_OE, .COLUMN_OUTPUTS);
`default_nettype wire

// >>> sim/lcd_ctl_model.sv
// Display controller model: nibbles, shift clock, latch pulse
`timescale 1ns/1ps
`default_nettype none
module lcd_ctl_model (
  // Clock in, controller pins out
  input wire logic  CLK,
  output logic      K, L,
  output logic [3:0] D
);
  initial {K, L, D} = 6'h00;
  task automatic send(input logic [79:0] b, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge CLK) {K, D} <= {1'b1, b[79-4*(k%20) -: 4]};
      repeat (5) @(posedge CLK);
      K <= 1'b0;
      repeat (5) @(posedge CLK);
      D <= ~D;
    end
  endtask
  task automatic latch;
    @(posedge CLK) L <= 1'b1;
    repeat (5) @(posedge CLK);
    L <= 1'b0;
    repeat (8) @(posedge CLK);
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_lcd_column_driver_chain.sv
// Self-checking bench for the LCD column driver chain
`timescale 1ns/1ps
`default_nettype none
module tb_lcd_column_driver_chain;
  logic clk = 0, rst_n = 0, s = 1, f = 1, ei = 1, k, l, ao, bo, ae, be;
  logic [3:0] d;
  logic [79:0] bits, cur = 0;
  logic [159:0] cols;
  int n_errors = 0, compares = 0, cyc = 0, seed = 99721;
  always #5 clk = ~clk;
  lcd_ctl_model ctl (.CLK(clk), .K(k), .L(l), .D(d));
  lcd_column_driver_chain dut (.CLK(clk), .RST_N(rst_n),
    .SHIFT_DIRECTION_SELECT(s), .NIBBLE_SHIFT_CLOCK(k),
    .LINE_LATCH_PULSE(l), .FRAME_POLARITY(f), .DISPLAY_NIBBLE_IN(d),
    .CHAIN_ENABLE_PORT_A_I(ae ? ao : ei),
    .CHAIN_ENABLE_PORT_B_I(be ? bo : ei), .CHAIN_ENABLE_PORT_A_O(ao),
    .CHAIN_ENABLE_PORT_A_OE(ae), .CHAIN_ENABLE_PORT_B_O(bo),
    .CHAIN_ENABLE_PORT_B_OE(be), .COLUMN_OUTPUTS(cols));
  function automatic logic [159:0] lv(input logic [79:0] v, input logic p);
    for (int c = 0; c < 80; c++) lv[2*c +: 2] = {~v[c], ~p};
  endfunction
  task automatic chk(input string nm, input logic [159:0] sn, e);
    compares++;
    if (sn !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, sn);
    end
  endtask
  task automatic summarize;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 5000) begin
    n_errors++;
    summarize;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    for (int r = 0; r < 6; r++) begin
      bits = 80'({$random(seed), $random(seed), $random(seed)});
      {s, f, ei} <= {r < 3, r[0], r != 4};
      ctl.send(bits, r == 1 ? 22 : 20);
      repeat (4) @(posedge clk);
      chk("enable out", s ? ao : bo, ei);
      chk("input port idle", s ? bo : ao, 0);
      if (r > 0) chk("columns held", cols, lv(cur, f));
      ctl.latch();
      if (ei) cur = s ? bits : {<<{bits}};
      chk("columns", cols, lv(cur, f));
      chk("enable cleared", s ? ao : bo, 0);
    end
    summarize;
  end
endmodule
`default_nettype wire
